// *** include/dac_cmd_pkg.sv ***
// shared constants for the four-channel dac command logic
// assumes a two-wire serial bus sampled by a 100 mhz system clock
package dac_cmd_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS      = 24;
   localparam int CMD_MSB         = 23;
   localparam int CMD_LSB         = 20;
   localparam int CHAN_SEL_LSB    = 16;
   localparam int DATA_MSB        = 15;
   localparam int MASK_LSB        = 0;
   localparam int REF_BIT         = 0;
   localparam int DAC_WIDTH       = 10;
   localparam int CHANNELS        = 4;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
   localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
   localparam logic [3:0] CMD_STROBE_MASK  = 4'h5;
   localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
   localparam logic [3:0] CMD_REF_SETUP    = 4'h7;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic       REF_DISABLE_RESET = 1'h0;
   localparam logic [3:0] MASK_RESET        = 4'h0;
   localparam logic [6:0] BUS_ADDRESS       = 7'h0c; // arbitrary value
   localparam int         POWER_UP_CYCLES   = 3;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_data,
      st_data_ack,
      st_skip
   } bus_state_type;

endpackage

// *** verilog/level_sync.sv ***
// two flip-flop synchroniser for one level from outside the clock domain
// assumes clock is the system clock; first stage feeds only the second
`timescale 1ns/1ns
module level_sync (
   input  wire logic clock,
   input  wire logic async_in,
   output logic      sync_out
);
   logic stage_one;
   logic next_stage_one;
   logic next_sync_out;

   always_comb begin
      next_stage_one = async_in;
      next_sync_out  = stage_one;
   end

   always_ff @(posedge clock) begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync_out;
   end
endmodule // level_sync

// *** verilog/dac_channel_registers.sv ***
// input register and dac register of one channel
// assumes control strobes are one-cycle pulses on the system clock
`timescale 1ns/1ns
module dac_channel_registers #(
   parameter int WIDTH = 10
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             preset,
   input  wire logic [WIDTH-1:0] preset_code,
   input  wire logic             write_input,
   input  wire logic             load_dac_data,
   input  wire logic             copy_input,
   input  wire logic [WIDTH-1:0] data,
   output logic      [WIDTH-1:0] input_value,
   output logic      [WIDTH-1:0] dac_value
);
   logic [WIDTH-1:0] next_input_value;
   logic [WIDTH-1:0] next_dac_value;

   if (WIDTH < 1 || WIDTH > 16) begin : width_check
      $error("dac_channel_registers: WIDTH must be 1 to 16");
   end

   always_comb begin
      next_input_value = input_value;
      next_dac_value   = dac_value;
      if (preset) begin
         next_input_value = preset_code;
         next_dac_value   = preset_code;
      end else begin
         if (write_input) begin
            next_input_value = data;
         end
         if (load_dac_data) begin
            next_dac_value = data;
         end else if (copy_input) begin
            next_dac_value = input_value;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         input_value <= '0;
         dac_value   <= '0;
      end else begin
         input_value <= next_input_value;
         dac_value   <= next_dac_value;
      end
   end
endmodule // dac_channel_registers

// *** verilog/dac_command_logic.sv ***
// command decode and register update control of a four-channel dac
// assumes two-wire bus pins, load strobe and level select come from
// outside the clock domain; clock is 100 mhz, srst synchronous
//
// Functional notes
// - select low: outputs power up zero
// - select high: outputs power up midscale
// - hold power-on level until valid write
// - 0001 writes input; dac if strobe low
// - 0010 copies input to dac register
// - 0011 writes input and dac registers
// - strobe falling edge updates unmasked channels
// - strobe held low ignores mask bits
// - internal reference enabled after power-up
// - 0111 loads reference off bit DB0
// - two-wire bus: clock and data
// - four-bit mask, one blocks strobe, reset zero
// - strobe low: update at last bit
// - 0110 restores power-on code
`timescale 1ns/1ns
module dac_command_logic
#(
   parameter logic [6:0] DEVICE_ADDRESS = dac_cmd_pkg::BUS_ADDRESS
) (
   input  wire logic                            clock,
   input  wire logic                            srst,
   input  wire logic                            scl,
   input  wire logic                            sda_in,
   output logic                                 sda_out,
   output logic                                 sda_oe,
   input  wire logic                            load_strobe_n,
   input  wire logic                            power_on_level_select,
   output logic [dac_cmd_pkg::DAC_WIDTH-1:0]    dac_code_a,
   output logic [dac_cmd_pkg::DAC_WIDTH-1:0]    dac_code_b,
   output logic [dac_cmd_pkg::DAC_WIDTH-1:0]    dac_code_c,
   output logic [dac_cmd_pkg::DAC_WIDTH-1:0]    dac_code_d,
   output logic                                 reference_disable_setting
);
   import dac_cmd_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic strobe_s;
   logic select_s;
   logic scl_q;
   logic sda_q;
   logic strobe_q;

   level_sync scl_sync (.clock(clock), .async_in(scl),
                        .sync_out(scl_s));
   level_sync sda_sync (.clock(clock), .async_in(sda_in), .sync_out(sda_s));
   level_sync strobe_sync (.clock(clock), .async_in(load_strobe_n),
                           .sync_out(strobe_s));
   level_sync select_sync (.clock(clock), .async_in(power_on_level_select),
                           .sync_out(select_s));

   always_ff @(posedge clock) begin
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      strobe_q <= strobe_s;
   end

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise   = scl_s & ~scl_q;
   assign scl_fall   = ~scl_s & scl_q;
   assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;

   // ----------------------------------------------------------------
   // power-on sequencing
   // ----------------------------------------------------------------
   logic [1:0] power_up_count;
   logic [1:0] next_power_up_count;
   logic       initializing;
   logic       power_up_preset;

   assign initializing    = power_up_count != 2'(POWER_UP_CYCLES);
   assign power_up_preset = power_up_count == 2'(POWER_UP_CYCLES - 1);

   always_comb begin
      next_power_up_count = power_up_count;
      if (initializing) begin
         next_power_up_count = power_up_count + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         power_up_count <= 2'h0;
      end else begin
         power_up_count <= next_power_up_count;
      end
   end

   // ----------------------------------------------------------------
   // serial bus receiver
   // ----------------------------------------------------------------
   bus_state_type state;
   bus_state_type next_state;
   logic [3:0]    bit_count;
   logic [3:0]    next_bit_count;
   logic [1:0]    byte_count;
   logic [1:0]    next_byte_count;
   logic [7:0]    shift;
   logic [7:0]    next_shift;
   logic [15:0]   frame_head;
   logic [15:0]   next_frame_head;
   logic          next_sda_oe;
   logic          exec;
   logic [23:0]   exec_frame;

   // frame complete on the rising clock of its 24th bit
   assign exec = state == st_data && scl_rise && bit_count == 4'h7 &&
                 byte_count == 2'h2 && !initializing;
   assign exec_frame = {frame_head, shift[6:0], sda_s};

   always_comb begin
      next_state      = state;
      next_bit_count  = bit_count;
      next_byte_count = byte_count;
      next_shift      = shift;
      next_frame_head = frame_head;
      next_sda_oe     = sda_oe;
      if (start_cond) begin
         next_state      = st_addr;
         next_bit_count  = 4'h0;
         next_byte_count = 2'h0;
         next_sda_oe     = 1'b0;
      end else if (stop_cond) begin
         next_state  = st_idle;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            st_addr, st_data: begin
               if (scl_rise && bit_count < 4'h8) begin
                  next_shift     = {shift[6:0], sda_s};
                  next_bit_count = bit_count + 4'h1;
               end else if (scl_fall && bit_count == 4'h8) begin
                  if (state == st_data) begin
                     next_state  = st_data_ack;
                     next_sda_oe = 1'b1;
                     if (byte_count == 2'h0) begin
                        next_frame_head[15:8] = shift;
                     end else if (byte_count == 2'h1) begin
                        next_frame_head[7:0] = shift;
                     end
                     next_byte_count = byte_count == 2'h2 ? 2'h0
                                                          : byte_count + 2'h1;
                  end else if (shift == {DEVICE_ADDRESS, 1'b0}) begin
                     next_state  = st_addr_ack;
                     next_sda_oe = 1'b1;
                  end else begin
                     next_state = st_skip;
                  end
               end
            end
            st_addr_ack, st_data_ack: begin
               if (scl_fall) begin
                  next_state     = st_data;
                  next_bit_count = 4'h0;
                  next_sda_oe    = 1'b0;
               end
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state      <= st_idle;
         bit_count  <= 4'h0;
         byte_count <= 2'h0;
         shift      <= 8'h00;
         frame_head <= 16'h0000;
         sda_oe     <= 1'b0;
         sda_out    <= 1'b0;
      end else begin
         state      <= next_state;
         bit_count  <= next_bit_count;
         byte_count <= next_byte_count;
         shift      <= next_shift;
         frame_head <= next_frame_head;
         sda_oe     <= next_sda_oe;
         sda_out    <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic [3:0]           command_code_field;
   logic [3:0]           chan_hit;
   logic [DAC_WIDTH-1:0] exec_data;
   logic                 strobe_fall;
   logic                 soft_reset;
   logic                 preset;
   logic [DAC_WIDTH-1:0] preset_code;
   logic [3:0]           strobe_mask;
   logic [3:0]           next_strobe_mask;
   logic                 next_reference_disable_setting;

   assign command_code_field = exec_frame[CMD_MSB:CMD_LSB];
   assign chan_hit    = exec_frame[CHAN_SEL_LSB +: CHANNELS];
   assign exec_data   = exec_frame[DATA_MSB -: DAC_WIDTH];
   assign strobe_fall = strobe_q & ~strobe_s & ~initializing;
   assign soft_reset  = exec && command_code_field == CMD_SOFT_RESET;
   assign preset      = power_up_preset | soft_reset;
   assign preset_code = select_s ? {1'b1, {(DAC_WIDTH-1){1'b0}}}
                                 : {DAC_WIDTH{1'b0}};

   always_comb begin
      next_strobe_mask               = strobe_mask;
      next_reference_disable_setting = reference_disable_setting;
      if (exec && command_code_field == CMD_STROBE_MASK) begin
         next_strobe_mask = exec_frame[MASK_LSB +: CHANNELS];
      end
      if (exec && command_code_field == CMD_REF_SETUP) begin
         next_reference_disable_setting = exec_frame[REF_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         strobe_mask               <= MASK_RESET;
         reference_disable_setting <= REF_DISABLE_RESET;
      end else begin
         strobe_mask               <= next_strobe_mask;
         reference_disable_setting <= next_reference_disable_setting;
      end
   end

   // ----------------------------------------------------------------
   // channel registers
   // ----------------------------------------------------------------
   logic [DAC_WIDTH-1:0] input_value [CHANNELS];
   logic [DAC_WIDTH-1:0] dac_value   [CHANNELS];

   for (genvar i = 0; i < CHANNELS; i++) begin : chan
      logic write_input;
      logic load_dac_data;
      logic copy_input;
      assign write_input = exec && chan_hit[i] &&
         (command_code_field == CMD_WRITE_INPUT ||
          command_code_field == CMD_WRITE_UPDATE);
      assign load_dac_data = exec && chan_hit[i] &&
         (command_code_field == CMD_WRITE_UPDATE ||
          (command_code_field == CMD_WRITE_INPUT && !strobe_s));
      assign copy_input = (exec && chan_hit[i] &&
         command_code_field == CMD_UPDATE_DAC) ||
         (strobe_fall && !strobe_mask[i]);
      dac_channel_registers #(.WIDTH(DAC_WIDTH)) regs (
         .clock        (clock),
         .srst         (srst),
         .preset       (preset),
         .preset_code  (preset_code),
         .write_input  (write_input),
         .load_dac_data(load_dac_data),
         .copy_input   (copy_input),
         .data         (exec_data),
         .input_value  (input_value[i]),
         .dac_value    (dac_value[i])
      );
   end

   assign dac_code_a = dac_value[0];
   assign dac_code_b = dac_value[1];
   assign dac_code_c = dac_value[2];
   assign dac_code_d = dac_value[3];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic a_write_input;
   logic a_update;
   logic a_write_both;
   assign a_write_input = exec && chan_hit[0] &&
                          command_code_field == CMD_WRITE_INPUT;
   assign a_update      = exec && chan_hit[0] &&
                          command_code_field == CMD_UPDATE_DAC;
   assign a_write_both  = exec && chan_hit[0] &&
                          command_code_field == CMD_WRITE_UPDATE;

   AST_POWER_UP_ZERO: assert property (@(posedge clock)
      disable iff (srst) power_up_preset && !select_s |=>
      dac_code_a == '0 && dac_code_d == '0)
      else $error("zero-scale power-up code missing");
   AST_POWER_UP_MID: assert property (@(posedge clock) disable iff (srst)
      power_up_preset && select_s |=> dac_code_b[DAC_WIDTH-1] &&
      dac_code_b[DAC_WIDTH-2:0] == '0)
      else $error("midscale power-up code missing");
   AST_HOLD_LEVEL: assert property (@(posedge clock) disable iff (srst)
      !initializing && !exec && !strobe_fall |=> $stable(dac_code_a))
      else $error("output moved without a write or strobe");
   AST_INPUT_ONLY: assert property (@(posedge clock) disable iff (srst)
      a_write_input && strobe_s |=> $stable(dac_code_a) &&
      input_value[0] == $past(exec_data))
      else $error("strobe-high input write changed dac register");
   AST_INSTANT: assert property (@(posedge clock) disable iff (srst)
      a_write_input && !strobe_s |=> dac_code_a == $past(exec_data) &&
      input_value[0] == $past(exec_data))
      else $error("strobe-low write did not update both registers");
   AST_COPY: assert property (@(posedge clock) disable iff (srst)
      a_update |=> dac_code_a == $past(input_value[0]) &&
      $stable(input_value[0]))
      else $error("update command did not copy input register");
   AST_WRITE_BOTH: assert property (@(posedge clock) disable iff (srst)
      a_write_both |=> dac_code_a == $past(exec_data) &&
      input_value[0] == $past(exec_data))
      else $error("write-update did not load both registers");
   AST_STROBE_COPY: assert property (@(posedge clock) disable iff (srst)
      strobe_fall && !strobe_mask[0] && !exec |=>
      dac_code_a == $past(input_value[0]))
      else $error("strobe edge did not update unmasked channel");
   AST_MASKED: assert property (@(posedge clock) disable iff (srst)
      strobe_fall && strobe_mask[0] && !exec |=> $stable(dac_code_a))
      else $error("masked channel followed the strobe");
   AST_REF_DEFAULT: assert property (@(posedge clock)
      $past(srst) && !srst |-> !reference_disable_setting)
      else $error("reference not enabled after reset");
   AST_REF_SET: assert property (@(posedge clock) disable iff (srst)
      exec && command_code_field == CMD_REF_SETUP |=>
      reference_disable_setting == $past(exec_frame[REF_BIT]))
      else $error("reference setting not loaded from DB0");
   AST_FULL_FRAME: assert property (@(posedge clock) disable iff (srst)
      exec |-> state == st_data && byte_count == 2'h2 && bit_count == 4'h7)
      else $error("command acted on before frame complete");
   AST_SOFT_RESET: assert property (@(posedge clock) disable iff (srst)
      soft_reset |=> dac_code_c == $past(preset_code))
      else $error("software reset did not restore power-on code");
endmodule // dac_command_logic

// *** tb/bus_controller_model.sv ***
// model of the two-wire bus controller that writes frames to the dac
// assumes the device acknowledges by pulling the data line through sda_oe
`timescale 1ns/1ns
module bus_controller_model (
   input  wire logic clock,
   input  wire logic sda_out,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda_line
);
   logic master_sda;

   // ------------------------------------------------------------
   // open-drain data line with pull-up, clock idles high
   // ------------------------------------------------------------
   assign sda_line = master_sda & ~(sda_oe & ~sda_out);

   initial begin
      scl        = 1'b1;
      master_sda = 1'b1;
   end

   // ------------------------------------------------------------
   // bus cycles, 8 system clocks per bus clock
   // ------------------------------------------------------------
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic start_cond();
      master_sda = 1'b1;
      scl        = 1'b1;
      wait_cyc(4);
      master_sda = 1'b0;
      wait_cyc(4);
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      wait_cyc(2);
      master_sda = 1'b0;
      wait_cyc(6);
      scl = 1'b1;
      wait_cyc(4);
      master_sda = 1'b1;
      wait_cyc(8);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         wait_cyc(2);
         master_sda = b[i];
         wait_cyc(2);
         scl = 1'b1;
         wait_cyc(4);
         scl = 1'b0;
      end
      wait_cyc(2);
      master_sda = 1'b1;
      wait_cyc(2);
      scl = 1'b1;
      wait_cyc(2);
      ack = ~sda_line;
      wait_cyc(2);
      scl = 1'b0;
   endtask

   // frame goes msb first; nbytes below 3 cuts it short with a stop
   task automatic send_frame(input logic [7:0] addr_byte,
                             input logic [23:0] frame,
                             input int nbytes, output int acks);
      logic a;
      acks = 0;
      start_cond();
      send_byte(addr_byte, a);
      acks += int'(a);
      for (int k = 0; k < nbytes; k++) begin
         send_byte(frame[23-8*k -: 8], a);
         acks += int'(a);
      end
      stop_cond();
   endtask
endmodule // bus_controller_model

// *** tb/test_quad_dac_update_command_logic.sv ***
// self-checking bench for the dac command logic against a queue-free model
// assumes bus_controller_model drives the two-wire bus pins
`timescale 1ns/1ns
module test_quad_dac_update_command_logic;
   import dac_cmd_pkg::*;
   logic                 clock, srst, load_strobe_n, power_on_level_select;
   logic                 scl, sda_line, sda_out, sda_oe;
   logic                 reference_disable_setting;
   logic [DAC_WIDTH-1:0] dac_code_a, dac_code_b, dac_code_c, dac_code_d;
   int                   err_total, check_count, cycle_count;
   int                   in_reg [4], dac_reg [4], mask, ref_dis, po_code;
   integer               seed;
   logic [31:0]          d;
   logic [3:0]           cmd_list [8] = '{4'h1, 4'h2, 4'h3, 4'h5,
                                          4'h7, 4'h0, 4'h1, 4'h3};

   dac_command_logic dac_command_logic_inst (
      .clock(clock), .srst(srst), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .load_strobe_n(load_strobe_n),
      .power_on_level_select(power_on_level_select),
      .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
      .dac_code_c(dac_code_c), .dac_code_d(dac_code_d),
      .reference_disable_setting(reference_disable_setting));

   bus_controller_model bus_controller_model_inst (
      .clock(clock), .sda_out(sda_out), .sda_oe(sda_oe),
      .scl(scl), .sda_line(sda_line));

   // ------------------------------------------------------------
   // clock, timeout and reporting
   // ------------------------------------------------------------
   initial clock = 1'b0;
   always #5 clock = ~clock;

   always @(posedge clock) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 40000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_all();
      check({6'h0, dac_code_a}, dac_reg[0][15:0]);
      check({6'h0, dac_code_b}, dac_reg[1][15:0]);
      check({6'h0, dac_code_c}, dac_reg[2][15:0]);
      check({6'h0, dac_code_d}, dac_reg[3][15:0]);
      check({15'h0, reference_disable_setting}, ref_dis[15:0]);
   endtask

   // ------------------------------------------------------------
   // model of the register updates
   // ------------------------------------------------------------
   task automatic apply(input logic [3:0] cmd, input logic [3:0] sel,
                        input logic [15:0] data);
      for (int ch = 0; ch < 4; ch++) begin
         if (cmd == CMD_SOFT_RESET) begin
            in_reg[ch]  = po_code;
            dac_reg[ch] = po_code;
         end else if (sel[ch]) begin
            if (cmd == CMD_WRITE_INPUT || cmd == CMD_WRITE_UPDATE)
               in_reg[ch] = int'(data[15:6]);
            if (cmd == CMD_UPDATE_DAC || cmd == CMD_WRITE_UPDATE ||
                (cmd == CMD_WRITE_INPUT && load_strobe_n == 1'b0))
               dac_reg[ch] = in_reg[ch];
         end
      end
      if (cmd == CMD_STROBE_MASK)
         mask = int'(data[3:0]);
      if (cmd == CMD_REF_SETUP)
         ref_dis = int'(data[REF_BIT]);
   endtask

   task automatic do_frame(input logic [7:0] ab, input logic [3:0] cmd,
                           input logic [3:0] sel, input logic [15:0] data,
                           input int nbytes);
      int acks;
      int exp_acks;
      exp_acks = (ab == {BUS_ADDRESS, 1'b0}) ? nbytes + 1 : 0;
      bus_controller_model_inst.send_frame(ab, {cmd, sel, data}, nbytes,
                                           acks);
      check(16'(acks), 16'(exp_acks));
      if (exp_acks == 4)
         apply(cmd, sel, data);
      repeat (4) @(negedge clock);
      check_all();
   endtask

   task automatic strobe_set(input logic level);
      for (int ch = 0; ch < 4; ch++)
         if (!level && load_strobe_n && !mask[ch])
            dac_reg[ch] = in_reg[ch];
      load_strobe_n = level;
      repeat (8) @(negedge clock);
      check_all();
   endtask

   task automatic do_reset(input logic sel);
      power_on_level_select = sel;
      srst = 1'b1;
      repeat (4) @(negedge clock);
      srst    = 1'b0;
      po_code = sel ? 512 : 0;
      mask    = 0;
      ref_dis = 0;
      for (int ch = 0; ch < 4; ch++) begin
         in_reg[ch]  = po_code;
         dac_reg[ch] = po_code;
      end
      repeat (12) @(negedge clock);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      srst                  = 1'b1;
      load_strobe_n         = 1'b1;
      power_on_level_select = 1'b0;
      err_total             = 0;
      check_count           = 0;
      cycle_count           = 0;
      seed                  = 32'hc2ef;
      @(negedge clock);
      do_reset(1'b0);
      check_all();
      do_reset(1'b1);
      check_all();
      d = $random(seed);
      do_frame({BUS_ADDRESS, 1'b0}, CMD_WRITE_INPUT, 4'hf, d[15:0], 3);
      d = $random(seed);
      do_frame({BUS_ADDRESS, 1'b0}, CMD_WRITE_UPDATE, 4'h2, d[15:0], 2);
      do_frame({BUS_ADDRESS, 1'b1}, CMD_WRITE_UPDATE, 4'h4, d[15:0], 3);
      do_frame({BUS_ADDRESS, 1'b0}, CMD_UPDATE_DAC, 4'h3, d[15:0], 3);
      do_frame({BUS_ADDRESS, 1'b0}, CMD_STROBE_MASK, 4'h0, 16'h0005, 3);
      strobe_set(1'b0);
      d = $random(seed);
      do_frame({BUS_ADDRESS, 1'b0}, CMD_WRITE_INPUT, 4'h5, d[15:0],
               3);
      strobe_set(1'b1);
      strobe_set(1'b0);
      for (int i = 0; i < 2; i++) begin
         d = $random(seed);
         do_frame({BUS_ADDRESS, 1'b0}, CMD_REF_SETUP, d[19:16],
                  {d[15:1], ~i[0]}, 3);
      end
      for (int i = 0; i < 14; i++) begin
         d = $random(seed);
         if (d[24])
            strobe_set(d[25]);
         do_frame({BUS_ADDRESS, 1'b0}, cmd_list[d[18:16]], d[23:20],
                  d[15:0], 3);
      end
      do_frame({BUS_ADDRESS, 1'b0}, CMD_SOFT_RESET, 4'h0, 16'h0000, 3);
      tally_and_finish();
   end
endmodule // test_quad_dac_update_command_logic
